//--- hw/xax_top.sv
// pointer selection, 24-bit external-data address forming and decode, fast port registers
`timescale 1ns/1ns
module xax_top #(
  parameter int NP = xax_pkg::NUM_PORTS
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // special register bus from the core
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata_q,
  output logic                   sfr_rvalid_q,
  // pointer operations from the core
  input  wire logic              ptr_inc,
  input  wire logic              ptr_load,
  input  wire logic [15:0]       ptr_imm,
  output logic      [15:0]       code_ptr_q,
  // external-data move request from the core
  input  wire logic              mv_req,
  input  wire logic              mv_via_ri,
  input  wire logic [7:0]        mv_ri_low,
  input  wire logic              mv_we,
  input  wire logic              mv_wide,
  input  wire logic [15:0]       mv_wdata,
  output logic                   mv_busy_q,
  output logic                   mv_done_q,
  output logic      [15:0]       mv_rdata_q,
  // decoded access toward the on-chip regions and off-chip memory
  output logic                   tgt_valid_q,
  output xax_pkg::xax_region_t   tgt_region_q,
  output logic      [23:0]       tgt_addr_q,
  output logic                   tgt_we_q,
  output logic                   tgt_wide_q,
  output logic      [15:0]       tgt_wdata_q,
  input  wire logic              tgt_done,
  input  wire logic [15:0]       tgt_rdata,
  // ports: hub data, pin levels, pin drive
  input  wire logic [NP*8-1:0]   hub_port_output_data,
  input  wire logic [NP*8-1:0]   pin_in,
  output logic      [NP*8-1:0]   pin_out_q
);

  // move sequencer states
  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} xax_state_t;

  // block registers
  xax_state_t  state_q;
  logic        pointer_select_q;
  logic [15:0] data_pointer_zero_q;
  logic [15:0] data_pointer_one_q;
  logic [7:0]  pointer0_high_extension_q;
  logic [7:0]  pointer1_high_extension_q;
  logic [7:0]  indirect_top_byte_q;
  logic [7:0]  indirect_middle_byte_q;

  // special register write decode
  // unknown or read-only addresses match nothing
  wire         wr_ptr0_lo   = sfr_wr && (sfr_addr == xax_pkg::SFR_PTR0_LOW);
  wire         wr_ptr0_hi   = sfr_wr && (sfr_addr == xax_pkg::SFR_PTR0_HIGH);
  wire         wr_ptr1_lo   = sfr_wr && (sfr_addr == xax_pkg::SFR_PTR1_LOW);
  wire         wr_ptr1_hi   = sfr_wr && (sfr_addr == xax_pkg::SFR_PTR1_HIGH);
  wire         wr_select    = sfr_wr && (sfr_addr == xax_pkg::SFR_PTR_SELECT);
  wire         wr_ext0      = sfr_wr && (sfr_addr == xax_pkg::SFR_PTR0_EXT);
  wire         wr_ext1      = sfr_wr && (sfr_addr == xax_pkg::SFR_PTR1_EXT);
  wire         wr_ind_top   = sfr_wr && (sfr_addr == xax_pkg::SFR_IND_TOP);
  wire         wr_ind_mid   = sfr_wr && (sfr_addr == xax_pkg::SFR_IND_MIDDLE);

  // active pointer and its extension byte
  // a load wins over an increment
  wire  [15:0] active_ptr   = pointer_select_q ? data_pointer_one_q
                                               : data_pointer_zero_q; // [RL1]
  wire  [7:0]  active_ext   = pointer_select_q ? pointer1_high_extension_q
                                               : pointer0_high_extension_q; // [RL3]
  wire  [15:0] ptr_next     = ptr_load ? ptr_imm : active_ptr + 16'h0001; // [RL1]
  wire         ptr_op       = ptr_load || ptr_inc;

  // 24-bit move address; extension bytes are only ever used here
  wire  [23:0] mv_addr      = mv_via_ri ? {indirect_top_byte_q, indirect_middle_byte_q, mv_ri_low}
                                        : {active_ext, active_ptr}; // [RL2] [RL3] [RL4] [RL9]

  // region decode of the move address
  // ranges are disjoint, so the order is arbitrary
  wire         in_sram      = (mv_addr <= xax_pkg::SRAM_HI); // [RL10]
  wire         in_timer     = (mv_addr >= xax_pkg::TIMER_LO) &&
                              (mv_addr <= xax_pkg::TIMER_HI); // [RL15]
  wire         in_portctl   = (mv_addr >= xax_pkg::PORTCTL_LO) &&
                              (mv_addr <= xax_pkg::PORTCTL_HI); // [RL11]
  wire         in_emifctl   = (mv_addr >= xax_pkg::EMIFCTL_LO) &&
                              (mv_addr <= xax_pkg::EMIFCTL_HI); // [RL15]
  wire         in_eeprom    = (mv_addr >= xax_pkg::EEPROM_LO) &&
                              (mv_addr <= xax_pkg::EEPROM_HI); // [RL12]
  wire         in_ecc       = (mv_addr >= xax_pkg::ECC_LO) &&
                              (mv_addr <= xax_pkg::ECC_HI); // [RL13]
  wire         in_extmem    = (mv_addr >= xax_pkg::EXTMEM_LO); // [RL14]

  xax_pkg::xax_region_t region_d;
  assign region_d = in_extmem  ? xax_pkg::RG_EXTMEM  :
                    in_ecc     ? xax_pkg::RG_ECC     :
                    in_eeprom  ? xax_pkg::RG_EEPROM  :
                    in_emifctl ? xax_pkg::RG_EMIFCTL :
                    in_portctl ? xax_pkg::RG_PORTCTL :
                    in_timer   ? xax_pkg::RG_TIMER   :
                    in_sram    ? xax_pkg::RG_SRAM    : xax_pkg::RG_NONE;

  // a move is taken only while idle
  wire         mv_take      = mv_req && (state_q == ST_IDLE);
  wire         mv_unmapped  = (region_d == xax_pkg::RG_NONE);

  // pointer select and extension registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pointer_select_q          <= 1'b0;
      pointer0_high_extension_q <= xax_pkg::RST_BYTE;
      pointer1_high_extension_q <= xax_pkg::RST_BYTE;
      indirect_top_byte_q       <= xax_pkg::RST_BYTE;
      indirect_middle_byte_q    <= xax_pkg::RST_BYTE;
    end else begin
      if (wr_select) begin
        pointer_select_q <= sfr_wdata[0];
      end
      if (wr_ext0) begin
        pointer0_high_extension_q <= sfr_wdata;
      end
      if (wr_ext1) begin
        pointer1_high_extension_q <= sfr_wdata;
      end
      if (wr_ind_top) begin
        indirect_top_byte_q <= sfr_wdata;
      end
      if (wr_ind_mid) begin
        indirect_middle_byte_q <= sfr_wdata;
      end
    end
  end

  // data pointer zero: core pointer operations win over register writes
  // so a register write in the same cycle is lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_pointer_zero_q <= xax_pkg::RST_POINTER;
    end else if (ptr_op && !pointer_select_q) begin
      data_pointer_zero_q <= ptr_next; // [RL1]
    end else begin
      if (wr_ptr0_lo) begin
        data_pointer_zero_q[7:0] <= sfr_wdata;
      end
      if (wr_ptr0_hi) begin
        data_pointer_zero_q[15:8] <= sfr_wdata;
      end
    end
  end

  // data pointer one: same scheme
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_pointer_one_q <= xax_pkg::RST_POINTER;
    end else if (ptr_op && pointer_select_q) begin
      data_pointer_one_q <= ptr_next; // [RL1]
    end else begin
      if (wr_ptr1_lo) begin
        data_pointer_one_q[7:0] <= sfr_wdata;
      end
      if (wr_ptr1_hi) begin
        data_pointer_one_q[15:8] <= sfr_wdata;
      end
    end
  end

  // code lookups and indexed jumps see only the 16-bit pointer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      code_ptr_q <= xax_pkg::RST_POINTER;
    end else begin
      code_ptr_q <= active_ptr; // [RL1] [RL2]
    end
  end

  // move sequencer: issue to a region, then wait for its answer
  // an unmapped move ends at once with zero data
  // a request while busy is dropped, not queued
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q      <= ST_IDLE;
      mv_busy_q    <= 1'b0;
      mv_done_q    <= 1'b0;
      mv_rdata_q   <= 16'h0000;
      tgt_valid_q  <= 1'b0;
      tgt_region_q <= xax_pkg::RG_NONE;
      tgt_addr_q   <= 24'h000000;
      tgt_we_q     <= 1'b0;
      tgt_wide_q   <= 1'b0;
      tgt_wdata_q  <= 16'h0000;
    end else begin
      mv_done_q   <= 1'b0;
      tgt_valid_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (mv_take && mv_unmapped) begin
            mv_done_q  <= 1'b1; // [RL17]
            mv_rdata_q <= 16'h0000;
          end else if (mv_take) begin
            state_q      <= ST_WAIT;
            mv_busy_q    <= 1'b1;
            tgt_valid_q  <= 1'b1;
            tgt_region_q <= region_d;
            tgt_addr_q   <= mv_addr; // [RL9]
            tgt_we_q     <= mv_we;
            tgt_wide_q   <= mv_wide && (region_d == xax_pkg::RG_EXTMEM); // [RL16]
            tgt_wdata_q  <= mv_wdata;
          end
        end
        ST_WAIT: begin
          if (tgt_done) begin
            state_q    <= ST_IDLE;
            mv_busy_q  <= 1'b0;
            mv_done_q  <= 1'b1;
            mv_rdata_q <= tgt_we_q ? 16'h0000
                        : (tgt_wide_q ? tgt_rdata : {8'h00, tgt_rdata[7:0]}); // [RL16]
          end
        end
      endcase
    end
  end

  // fast-access ports
  // index 7 is port 12 and index 8 is port 15
  logic [NP*8-1:0] port_data;
  logic [NP*8-1:0] port_select;
  logic [NP*8-1:0] port_state;
  logic [NP-1:0][7:0] port_rd;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_port
      wire hit_data   = (sfr_addr == xax_pkg::PORT_DATA_ADDR[gi]);
      wire hit_state  = (sfr_addr == xax_pkg::PORT_STATE_ADDR[gi]);
      wire hit_select = (sfr_addr == xax_pkg::PORT_SELECT_ADDR[gi]);

      xax_port_mux #(
        .W (8)
      ) u_port (
        .clk       (clk),
        .rst_b     (rst_b),
        .data_we   (sfr_wr && hit_data),
        .select_we (sfr_wr && hit_select), // [RL5]
        .wdata     (sfr_wdata),
        .hub_data  (hub_port_output_data[gi*8 +: 8]),
        .pin_in    (pin_in[gi*8 +: 8]),
        .data_q    (port_data[gi*8 +: 8]),
        .select_q  (port_select[gi*8 +: 8]),
        .state_q   (port_state[gi*8 +: 8]),
        .pin_out_q (pin_out_q[gi*8 +: 8])
      );

      // read value of this port's three registers
      assign port_rd[gi] = hit_data   ? port_data[gi*8 +: 8]   :
                           hit_state  ? port_state[gi*8 +: 8]  :
                           hit_select ? port_select[gi*8 +: 8] : 8'h00; // [RL5] [RL8]
    end
  endgenerate

  // or-reduce the port read values; only one can be non-zero
  logic [7:0] port_rd_any;
  always_comb begin
    port_rd_any = 8'h00;
    for (int i = 0; i < NP; i++) begin
      port_rd_any = port_rd_any | port_rd[i];
    end
  end

  // special register read mux; unknown addresses read zero
  wire  [7:0] sfr_rd_d =
    (sfr_addr == xax_pkg::SFR_PTR0_LOW)   ? data_pointer_zero_q[7:0]  :
    (sfr_addr == xax_pkg::SFR_PTR0_HIGH)  ? data_pointer_zero_q[15:8] :
    (sfr_addr == xax_pkg::SFR_PTR1_LOW)   ? data_pointer_one_q[7:0]   :
    (sfr_addr == xax_pkg::SFR_PTR1_HIGH)  ? data_pointer_one_q[15:8]  :
    (sfr_addr == xax_pkg::SFR_PTR_SELECT) ? {7'h00, pointer_select_q} :
    (sfr_addr == xax_pkg::SFR_PTR0_EXT)   ? pointer0_high_extension_q :
    (sfr_addr == xax_pkg::SFR_PTR1_EXT)   ? pointer1_high_extension_q :
    (sfr_addr == xax_pkg::SFR_IND_TOP)    ? indirect_top_byte_q       :
    (sfr_addr == xax_pkg::SFR_IND_MIDDLE) ? indirect_middle_byte_q    : port_rd_any;

  // registered read answer, one cycle after the request
  // the data holds until the next read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata_q  <= xax_pkg::RST_BYTE;
      sfr_rvalid_q <= 1'b0;
    end else begin
      sfr_rvalid_q <= sfr_rd;
      if (sfr_rd) begin
        sfr_rdata_q <= sfr_rd_d;
      end
    end
  end

endmodule : xax_top

//--- hw/xax_pkg.sv
// package of addresses, reset values and types for the external-data address extension block
// Operation
// RL1 - The pointer select bit picks data pointer zero or one for every pointer-based operation.
// RL2 - The high-address extension registers feed external-data moves and nothing else.
// RL3 - A pointer move takes its top address byte from that pointer's extension register.
// RL4 - A working-register move takes its top and middle bytes from the two indirect registers.
// RL5 - Ports 0 to 6, 12 and 15 each have a fast data, a fast select and a pin state register.
// RL6 - A pin whose select bit is one is driven from the matching fast data bit, for pins 0 to 7.
// RL7 - A pin whose select bit is zero is driven from the matching hub port data bit.
// RL8 - The pin state register reads the present pin levels and ignores writes.
// RL9 - External-data addresses are 24 bits wide, covering 16 MB.
// RL10 - Addresses 000000 to 001fff go to on-chip static RAM.
// RL11 - Addresses 005000 to 0051ff go to the port control registers.
// RL12 - Addresses 008000 to 008fff go to the EEPROM array.
// RL13 - Addresses 080000 to 081fff go to the flash error-correction bytes.
// RL14 - Addresses 800000 to ffffff go to the off-chip external memory interface.
// RL15 - 004f00-004fff go to the timer registers, 005400-0054ff to memory interface control.
// RL16 - Off-chip moves may be 8 or 16 bits wide, one memory type at a time.
// RL17 - Moves to unlisted addresses finish with no side effect, reading zero and dropping writes.
package xax_pkg;

  // special function register addresses
  localparam logic [7:0] SFR_PTR0_LOW    = 8'h82;
  localparam logic [7:0] SFR_PTR0_HIGH   = 8'h83;
  localparam logic [7:0] SFR_PTR1_LOW    = 8'h84;
  localparam logic [7:0] SFR_PTR1_HIGH   = 8'h85;
  localparam logic [7:0] SFR_PTR_SELECT  = 8'h86;
  localparam logic [7:0] SFR_PTR0_EXT    = 8'h93;
  localparam logic [7:0] SFR_PTR1_EXT    = 8'h95;
  localparam logic [7:0] SFR_IND_TOP     = 8'hea;
  localparam logic [7:0] SFR_IND_MIDDLE  = 8'ha0;

  // fast port registers, index 0..8 stands for ports 0,1,2,3,4,5,6,12,15
  localparam int NUM_PORTS = 9;
  localparam logic [NUM_PORTS-1:0][7:0] PORT_DATA_ADDR =
    {8'hf8, 8'he8, 8'hd8, 8'hc8, 8'hc0, 8'hb0, 8'h98, 8'h90, 8'h80};
  localparam logic [NUM_PORTS-1:0][7:0] PORT_STATE_ADDR =
    {8'hf9, 8'he9, 8'hd9, 8'hc9, 8'hc1, 8'hb1, 8'h99, 8'h91, 8'h89};
  localparam logic [NUM_PORTS-1:0][7:0] PORT_SELECT_ADDR =
    {8'hfa, 8'hf2, 8'hda, 8'hca, 8'hc2, 8'hb2, 8'h9a, 8'ha2, 8'h8a};

  // reset values
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_POINTER = 16'h0000;

  // external-data address width and region bounds
  localparam int          XADDR_W        = 24;
  localparam logic [23:0] SRAM_LO        = 24'h000000;
  localparam logic [23:0] SRAM_HI        = 24'h001fff;
  localparam logic [23:0] TIMER_LO       = 24'h004f00;
  localparam logic [23:0] TIMER_HI       = 24'h004fff;
  localparam logic [23:0] PORTCTL_LO     = 24'h005000;
  localparam logic [23:0] PORTCTL_HI     = 24'h0051ff;
  localparam logic [23:0] EMIFCTL_LO     = 24'h005400;
  localparam logic [23:0] EMIFCTL_HI     = 24'h0054ff;
  localparam logic [23:0] EEPROM_LO      = 24'h008000;
  localparam logic [23:0] EEPROM_HI      = 24'h008fff;
  localparam logic [23:0] ECC_LO         = 24'h080000;
  localparam logic [23:0] ECC_HI         = 24'h081fff;
  localparam logic [23:0] EXTMEM_LO      = 24'h800000;

  // decoded target of an external-data move
  typedef enum logic [2:0] {
    RG_NONE,
    RG_SRAM,
    RG_TIMER,
    RG_PORTCTL,
    RG_EMIFCTL,
    RG_EEPROM,
    RG_ECC,
    RG_EXTMEM
  } xax_region_t;

endpackage : xax_pkg

//--- hw/xax_port_mux.sv
// one fast-access i/o port: data and select registers, pin synchroniser, output mux
`timescale 1ns/1ns
module xax_port_mux #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // register writes from the special register bus
  input  wire logic         data_we,
  input  wire logic         select_we,
  input  wire logic [W-1:0] wdata,
  // pins and hub side
  input  wire logic [W-1:0] hub_data,
  input  wire logic [W-1:0] pin_in,
  // register contents and pin drive
  output logic      [W-1:0] data_q,
  output logic      [W-1:0] select_q,
  output logic      [W-1:0] state_q,
  output logic      [W-1:0] pin_out_q
);

  logic [W-1:0] pin_meta_q;
  logic [W-1:0] drive_d;

  // per-pin choice between fast data and hub data
  assign drive_d = (select_q & data_q) | (~select_q & hub_data); // [RL6] [RL7]

  // fast data and select registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q   <= xax_pkg::RST_BYTE;
      select_q <= xax_pkg::RST_BYTE;
    end else begin
      if (data_we) data_q <= wdata;
      if (select_we) select_q <= wdata;
    end
  end

  // two-stage pin synchroniser; state register has no write path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_q <= xax_pkg::RST_BYTE;
      state_q    <= xax_pkg::RST_BYTE;
      pin_out_q  <= xax_pkg::RST_BYTE;
    end else begin
      pin_meta_q <= pin_in;
      state_q    <= pin_meta_q; // [RL8]
      pin_out_q  <= drive_d;
    end
  end

endmodule : xax_port_mux

//--- test/xax_top_checker.sv
// concurrent checks on the ports of the external-data address extension block
`timescale 1ns/1ns
module xax_top_checker (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst_b,
  // register bus
  input wire logic                 sfr_rd,
  input wire logic [7:0]           sfr_addr,
  input wire logic [7:0]           sfr_rdata_q,
  input wire logic                 sfr_rvalid_q,
  // moves and decoded access
  input wire logic                 mv_req,
  input wire logic                 mv_via_ri,
  input wire logic [7:0]           mv_ri_low,
  input wire logic                 mv_busy_q,
  input wire logic                 mv_done_q,
  input wire logic                 tgt_valid_q,
  input wire xax_pkg::xax_region_t tgt_region_q,
  input wire logic [23:0]          tgt_addr_q,
  input wire logic                 tgt_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // register reads and pointer select
  AST_RD_ANSWER: assert property (sfr_rd |=> sfr_rvalid_q)
    else $error("register read got no answer");
  AST_SEL_BITS: assert property (sfr_rd && sfr_addr == xax_pkg::SFR_PTR_SELECT
    |=> sfr_rdata_q[7:1] == 7'h00) else $error("pointer select upper bits not zero");
  // low address byte of a working-register move
  AST_RI_LOW: assert property (mv_req && !mv_busy_q && mv_via_ri
    |=> !tgt_valid_q || tgt_addr_q[7:0] == $past(mv_ri_low)) else $error("low byte wrong");
  // region decode of issued accesses
  AST_SRAM: assert property (tgt_valid_q && tgt_addr_q <= 24'h001fff
    |-> tgt_region_q == xax_pkg::RG_SRAM) else $error("static ram decode wrong");
  AST_PORTCTL: assert property (tgt_valid_q
    && tgt_addr_q inside {[24'h005000:24'h0051ff]}
    |-> tgt_region_q == xax_pkg::RG_PORTCTL) else $error("port control decode wrong");
  AST_EEPROM: assert property (tgt_valid_q && tgt_addr_q inside {[24'h008000:24'h008fff]}
    |-> tgt_region_q == xax_pkg::RG_EEPROM) else $error("eeprom decode wrong");
  AST_ECC: assert property (tgt_valid_q && tgt_addr_q inside {[24'h080000:24'h081fff]}
    |-> tgt_region_q == xax_pkg::RG_ECC) else $error("ecc decode wrong");
  AST_EXTMEM: assert property (tgt_valid_q && tgt_addr_q[23]
    |-> tgt_region_q == xax_pkg::RG_EXTMEM) else $error("off-chip decode wrong");
  AST_TIMER: assert property (tgt_valid_q && tgt_addr_q[23:8] == 16'h004f
    |-> tgt_region_q == xax_pkg::RG_TIMER) else $error("timer decode wrong");
  // move completion
  AST_ISSUE: assert property (tgt_valid_q
    |-> mv_busy_q && tgt_region_q != xax_pkg::RG_NONE)
    else $error("issued access without region");
  AST_TAKEN: assert property (mv_req && !mv_busy_q |=> tgt_valid_q ^ mv_done_q)
    else $error("move neither issued nor finished");
  AST_DONE: assert property (mv_busy_q && tgt_done |=> mv_done_q && !mv_busy_q)
    else $error("move not finished after region answer");
endmodule : xax_top_checker

bind xax_top xax_top_checker u_chk (
  .clk(clk), .rst_b(rst_b), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
  .sfr_rdata_q(sfr_rdata_q), .sfr_rvalid_q(sfr_rvalid_q), .mv_req(mv_req),
  .mv_via_ri(mv_via_ri), .mv_ri_low(mv_ri_low), .mv_busy_q(mv_busy_q),
  .mv_done_q(mv_done_q), .tgt_valid_q(tgt_valid_q), .tgt_region_q(tgt_region_q),
  .tgt_addr_q(tgt_addr_q), .tgt_done(tgt_done)
);

//--- test/xax_region_model.sv
// behavioural on-chip regions and off-chip memory answering decoded accesses
`timescale 1ns/1ns
module xax_region_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // access from the block and stall length
  input  wire logic        tgt_valid_q,
  input  wire logic [23:0] tgt_addr_q,
  input  wire logic [3:0]  dly,
  // answer
  output logic             tgt_done,
  output logic [15:0]      tgt_rdata
);
  logic [3:0]  cnt;
  logic [15:0] junk;
  // stall for dly cycles, then answer one cycle; data churns outside the answer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt      <= 4'h0;
      tgt_done <= 1'b0;
      junk     <= 16'h1234;
    end else begin
      junk     <= junk + 16'h3b17;
      tgt_done <= tgt_valid_q ? (dly == 4'h0) : (cnt == 4'h1);
      if (tgt_valid_q) begin
        cnt <= dly;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
  assign tgt_rdata = tgt_done ? (tgt_addr_q[15:0] ^ 16'ha5c3) : junk;
endmodule : xax_region_model

//--- test/tb.sv
// self-checking bench for the external-data address extension block
`timescale 1ns/1ns
module tb;
  localparam int NP = xax_pkg::NUM_PORTS;
  logic clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, ptr_inc = 0, ptr_load = 0;
  logic mv_req = 0, mv_via_ri = 0, mv_we = 0, mv_wide = 0;
  logic [7:0]  sfr_addr = 0, sfr_wdata = 0, mv_ri_low = 0, fd, sl;
  logic [15:0] ptr_imm = 0, mv_wdata = 0, imm, p0;
  logic [3:0]  dly = 0;
  logic [NP*8-1:0] hub = 0, pins = 0;
  wire  [7:0]  sfr_rdata_q;
  wire  [15:0] code_ptr_q, mv_rdata_q, tgt_wdata_q, tgt_rdata;
  wire  [23:0] tgt_addr_q;
  wire  [NP*8-1:0] pin_out_q;
  wire  sfr_rvalid_q, mv_busy_q, mv_done_q, tgt_valid_q, tgt_we_q, tgt_wide_q, tgt_done;
  xax_pkg::xax_region_t tgt_region_q;
  wire  [44:0] tgt_seen = {tgt_wdata_q, tgt_wide_q, tgt_we_q, tgt_region_q, tgt_addr_q};
  logic [7:0]  rq[$];
  logic [15:0] mq[$];
  logic [44:0] tq[$];
  int num_errors = 0, n_compared = 0;
  logic [23:0] adr[18] = '{24'h001fff, 24'h002000, 24'h004eff, 24'h004f00, 24'h004fff,
    24'h005000, 24'h0051ff, 24'h005200, 24'h005400, 24'h0054ff, 24'h008000, 24'h008fff,
    24'h080000, 24'h081fff, 24'h082000, 24'h7fffff, 24'h800000, 24'hffffff};

  // design and far-side model
  xax_top uut (.clk(clk), .rst_b(rst_b), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .sfr_rvalid_q(sfr_rvalid_q),
    .ptr_inc(ptr_inc), .ptr_load(ptr_load), .ptr_imm(ptr_imm), .code_ptr_q(code_ptr_q),
    .mv_req(mv_req), .mv_via_ri(mv_via_ri), .mv_ri_low(mv_ri_low), .mv_we(mv_we),
    .mv_wide(mv_wide), .mv_wdata(mv_wdata), .mv_busy_q(mv_busy_q), .mv_done_q(mv_done_q),
    .mv_rdata_q(mv_rdata_q), .tgt_valid_q(tgt_valid_q), .tgt_region_q(tgt_region_q),
    .tgt_addr_q(tgt_addr_q), .tgt_we_q(tgt_we_q), .tgt_wide_q(tgt_wide_q),
    .tgt_wdata_q(tgt_wdata_q), .tgt_done(tgt_done), .tgt_rdata(tgt_rdata),
    .hub_port_output_data(hub), .pin_in(pins), .pin_out_q(pin_out_q));
  xax_region_model u_mem (.clk(clk), .rst_b(rst_b), .tgt_valid_q(tgt_valid_q),
    .tgt_addr_q(tgt_addr_q), .dly(dly), .tgt_done(tgt_done), .tgt_rdata(tgt_rdata));

  always #4 clk = ~clk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  function automatic xax_pkg::xax_region_t region(input logic [23:0] a);
    if (a <= 24'h001fff) return xax_pkg::RG_SRAM;
    if (a[23:8] == 16'h004f) return xax_pkg::RG_TIMER;
    if (a inside {[24'h005000:24'h0051ff]}) return xax_pkg::RG_PORTCTL;
    if (a[23:8] == 16'h0054) return xax_pkg::RG_EMIFCTL;
    if (a[23:12] == 12'h008) return xax_pkg::RG_EEPROM;
    if (a[23:13] == 11'h040) return xax_pkg::RG_ECC;
    if (a[23]) return xax_pkg::RG_EXTMEM;
    return xax_pkg::RG_NONE;
  endfunction : region

  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : sw

  task automatic sr(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    {sfr_rd, sfr_addr} = {1'b1, a};
    rq.push_back(e);
    @(negedge clk);
    sfr_rd = 1'b0;
  endtask : sr

  task automatic ptr_op(input logic ld);
    @(negedge clk);
    {ptr_load, ptr_inc} = {ld, !ld};
    @(negedge clk);
    {ptr_load, ptr_inc} = 2'b00;
    repeat (3) @(negedge clk);
  endtask : ptr_op

  // address set-up through pointer p or working register, then one move
  task automatic mv(input logic ri, input logic p, input logic we, input logic wd,
                    input logic [23:0] a);
    xax_pkg::xax_region_t r;
    logic [15:0] f;
    r = region(a);
    f = a[15:0] ^ 16'ha5c3;
    sw(p ? xax_pkg::SFR_PTR1_EXT : xax_pkg::SFR_PTR0_EXT, ri ? ~a[23:16] : a[23:16]);
    sw(p ? xax_pkg::SFR_PTR1_HIGH : xax_pkg::SFR_PTR0_HIGH, a[15:8]);
    sw(p ? xax_pkg::SFR_PTR1_LOW : xax_pkg::SFR_PTR0_LOW, ri ? ~a[7:0] : a[7:0]);
    sw(xax_pkg::SFR_IND_TOP, ri ? a[23:16] : ~a[23:16]);
    sw(xax_pkg::SFR_IND_MIDDLE, ri ? a[15:8] : ~a[15:8]);
    sw(xax_pkg::SFR_PTR_SELECT, {7'h00, p});
    @(negedge clk);
    {mv_req, mv_via_ri, mv_ri_low, mv_we, mv_wide} = {1'b1, ri, a[7:0], we, wd};
    mv_wdata = 16'($urandom);
    if (r != xax_pkg::RG_NONE) tq.push_back({mv_wdata, wd && r == xax_pkg::RG_EXTMEM, we, r, a});
    mq.push_back((we || r == xax_pkg::RG_NONE) ? 16'h0000 :
                 (wd && r == xax_pkg::RG_EXTMEM) ? f : {8'h00, f[7:0]});
    @(negedge clk);
    mv_req = 1'b0;
    for (int i = 0; i < 40 && mv_done_q !== 1'b1; i++) @(negedge clk);
  endtask : mv

  // output watcher: each result takes the oldest expectation of its kind
  always @(negedge clk) begin
    if (sfr_rvalid_q === 1'b1) chk(sfr_rdata_q, rq.size() ? rq.pop_front() : 'x);
    if (tgt_valid_q === 1'b1) chk(tgt_seen, tq.size() ? tq.pop_front() : 'x);
    if (mv_done_q === 1'b1) chk(mv_rdata_q, mq.size() ? mq.pop_front() : 'x);
  end

  initial begin
    #(8 * 40000);
    num_errors++;
    finish_test();
  end

  // main sequence
  initial begin
    void'($urandom(22250));
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    for (int a = 8'h82; a <= 8'h87; a++) sr(8'(a), 8'h00);
    sw(8'h87, 8'h5a);
    sr(8'h87, 8'h00);
    for (int p = 0; p < 2; p++) begin
      sw(xax_pkg::SFR_PTR_SELECT, p ? 8'hff : 8'h00);
      sr(xax_pkg::SFR_PTR_SELECT, 8'(p));
      imm = 16'($urandom);
      ptr_imm = imm;
      ptr_op(1'b1);
      chk(code_ptr_q, imm);
      sr(p ? xax_pkg::SFR_PTR1_HIGH : xax_pkg::SFR_PTR0_HIGH, imm[15:8]);
      ptr_op(1'b0);
      chk(code_ptr_q, imm + 16'h0001);
      if (p == 0) p0 = imm + 16'h0001;
    end
    sw(xax_pkg::SFR_PTR_SELECT, 8'h00);
    repeat (3) @(negedge clk);
    chk(code_ptr_q, p0);
    for (int i = 0; i < NP; i++) begin
      {fd, sl} = 16'($urandom);
      hub[i*8+:8] = 8'($urandom);
      pins[i*8+:8] = 8'($urandom);
      sr(xax_pkg::PORT_DATA_ADDR[i], 8'h00);
      sw(xax_pkg::PORT_DATA_ADDR[i], fd);
      sw(xax_pkg::PORT_SELECT_ADDR[i], sl);
      repeat (3) @(negedge clk);
      chk(pin_out_q[i*8+:8], (sl & fd) | (~sl & hub[i*8+:8]));
      sr(xax_pkg::PORT_SELECT_ADDR[i], sl);
      sw(xax_pkg::PORT_STATE_ADDR[i], ~pins[i*8+:8]);
      sr(xax_pkg::PORT_STATE_ADDR[i], pins[i*8+:8]);
    end
    foreach (adr[i]) begin
      dly = 4'($urandom % 4);
      mv(i % 2, (i / 2) % 2, 1'($urandom), 1'($urandom), adr[i]);
    end
    for (int i = 0; i < 24; i++) begin
      dly = 4'($urandom % 6);
      mv(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 24'($urandom));
    end
    repeat (4) @(negedge clk);
    chk(rq.size() + mq.size() + tq.size(), 0);
    finish_test();
  end
endmodule : tb
